// ### rtl/pmt_pkg.sv
// Package of register map, field positions and timing constants for the power-management block.
package pmt_pkg;

  // ==========================================================================
  // Register byte addresses (word aligned on APB).
  localparam logic [7:0] ADDR_TIMEOUT_PERIOD = 8'h00;
  localparam logic [7:0] ADDR_RELOAD_CFG     = 8'h04;
  localparam logic [7:0] ADDR_TIMEOUT_STATUS = 8'h08;
  localparam logic [7:0] ADDR_EVT_BASE_LO    = 8'h0C;
  localparam logic [7:0] ADDR_EVT_BASE_HI    = 8'h10;
  localparam logic [7:0] ADDR_TMR_BASE_LO    = 8'h14;
  localparam logic [7:0] ADDR_TMR_BASE_HI    = 8'h18;
  localparam logic [7:0] ADDR_CTL_BASE_LO    = 8'h1C;
  localparam logic [7:0] ADDR_CTL_BASE_HI    = 8'h20;
  localparam logic [7:0] ADDR_GP_BASE_LO     = 8'h24;
  localparam logic [7:0] ADDR_GP_BASE_HI     = 8'h28;
  localparam logic [7:0] ADDR_ACPI_SUPPORT   = 8'h2C;

  // ==========================================================================
  // Reset values and writable masks.
  localparam logic [7:0] PERIOD_RESET   = 8'h00;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [7:0] STATUS_RESET   = 8'h01;
  localparam logic [7:0] BASE_RESET     = 8'h00;
  localparam logic [7:0] SUPPORT_RESET  = 8'h00;
  localparam logic [7:0] CFG_WMASK      = 8'h0F;
  localparam logic [7:0] EVT_LO_WMASK   = 8'hFC;
  localparam logic [7:0] TMR_LO_WMASK   = 8'hFC;
  localparam logic [7:0] CTL_LO_WMASK   = 8'hFE;
  localparam logic [7:0] GP_LO_WMASK    = 8'hF0;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;

  // ==========================================================================
  // Support register field positions.
  localparam int SUP_SLEEP_STS = 0;
  localparam int SUP_SLEEP_EN  = 1;
  localparam int SUP_LOCK_STS  = 2;
  localparam int SUP_LOCK_EN   = 3;
  localparam int SUP_BIOS_REL  = 4;
  localparam int SUP_SMI_STS   = 5;
  localparam int SUP_SMI_EN    = 6;
  localparam int SUP_MASK_EVT  = 7;
  localparam logic [7:0] SUP_RW_MASK = 8'hCA;
  localparam logic [7:0] SUP_W1C_MASK = 8'h25;

  // ==========================================================================
  // Timing: one decrement per minute at a 20 MHz clock.
  localparam longint CLK_HZ        = 64'd20000000;
  localparam longint MINUTE_S      = 64'd60;
  localparam longint MINUTE_CYCLES = CLK_HZ * MINUTE_S;
  localparam int     NUM_SOURCES   = 4;

endpackage

// ### rtl/pmt_timeout_acpi.sv
// Supervision timer, reload triggers and ACPI support registers behind an APB slave.
`timescale 1ns/1ps
module pmt_timeout_acpi
  import pmt_pkg::*;
#(
  parameter longint MINUTE_TICKS = MINUTE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        soft_reset,
  input  wire logic        activate,
  input  wire logic [3:0]  irq_sources,
  input  wire logic        sleep_enable_write,
  input  wire logic        lock_release_write,
  input  wire logic        smi_command_write,
  output logic             timeout_out_n,
  output logic             power_event_req_n,
  output logic             lock_status_set,
  output logic             event_mask_only
);

  // ==========================================================================
  // Bus decode.
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  wbyte;
  logic        addr_ok;
  logic        dev_clear;
  assign wr_en     = psel && penable && pwrite && pready;
  assign rd_en     = psel && penable && !pwrite;
  assign wbyte     = pstrb[0] ? pwdata[7:0] : ZERO_BYTE;
  assign dev_clear = soft_reset || activate;

  // Checks that the byte address hits a mapped register.
  always_comb begin
    unique case (paddr)
      ADDR_TIMEOUT_PERIOD, ADDR_RELOAD_CFG, ADDR_TIMEOUT_STATUS,
      ADDR_EVT_BASE_LO, ADDR_EVT_BASE_HI, ADDR_TMR_BASE_LO,
      ADDR_TMR_BASE_HI, ADDR_CTL_BASE_LO, ADDR_CTL_BASE_HI,
      ADDR_GP_BASE_LO, ADDR_GP_BASE_HI, ADDR_ACPI_SUPPORT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  logic wr_b0;
  assign wr_b0 = wr_en && pstrb[0];

  // ==========================================================================
  // Registers.
  logic [7:0] timeout_period_reg;
  logic [7:0] reload_trigger_config_reg;
  logic [7:0] base_reg [0:7];
  logic [7:0] acpi_support_reg;

  // Holds the programmed period; device activation and software reset clear it.
  // hardware reset clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_period_reg <= PERIOD_RESET;
    end else if (dev_clear) begin
      timeout_period_reg <= PERIOD_RESET;
    end else if (wr_b0 && paddr == ADDR_TIMEOUT_PERIOD) begin
      timeout_period_reg <= pwdata[7:0];
    end
  end

  // Holds the trigger enables, low four bits only.
  // enables cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_trigger_config_reg <= CFG_RESET;
    end else if (dev_clear) begin
      reload_trigger_config_reg <= CFG_RESET;
    end else if (wr_b0 && paddr == ADDR_RELOAD_CFG) begin
      reload_trigger_config_reg <= pwdata[7:0] & CFG_WMASK;
    end
  end

  // Base-address bytes: even entries are low bytes with read-only low bits.
  logic [7:0] base_addr [0:7];
  logic [7:0] base_mask [0:7];
  assign base_addr = '{ADDR_EVT_BASE_LO, ADDR_EVT_BASE_HI, ADDR_TMR_BASE_LO,
                       ADDR_TMR_BASE_HI, ADDR_CTL_BASE_LO, ADDR_CTL_BASE_HI,
                       ADDR_GP_BASE_LO, ADDR_GP_BASE_HI};
  assign base_mask = '{EVT_LO_WMASK, 8'hFF, TMR_LO_WMASK, 8'hFF,
                       CTL_LO_WMASK, 8'hFF, GP_LO_WMASK, 8'hFF};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_base
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          base_reg[gi] <= BASE_RESET;
        end else if (wr_b0 && paddr == base_addr[gi]) begin
          base_reg[gi] <= pwdata[7:0] & base_mask[gi];
        end
      end
    end
  endgenerate

  // Support register: sticky flags set by hardware win over a software clear.
  logic [7:0] sup_w1c;
  logic [7:0] sup_set;
  logic       sup_wr;
  assign sup_wr  = wr_b0 && paddr == ADDR_ACPI_SUPPORT;
  assign sup_w1c = sup_wr ? (wbyte & SUP_W1C_MASK) : ZERO_BYTE;
  assign sup_set = {2'b00, smi_command_write, 2'b00, lock_release_write,
                    1'b0, sleep_enable_write};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acpi_support_reg <= SUPPORT_RESET;
    end else begin
      acpi_support_reg <= ((acpi_support_reg & ~sup_w1c) | sup_set) & ~SUP_RW_MASK
                          | (sup_wr ? (wbyte & SUP_RW_MASK) : (acpi_support_reg & SUP_RW_MASK));
    end
  end

  // ==========================================================================
  // Supervision timer.
  logic [7:0]  count_reg;
  logic [31:0] tick_reg;
  logic        running_reg;
  logic        trigger;
  logic        tick_done;
  logic        period_wr;
  assign trigger   = |(irq_sources & reload_trigger_config_reg[NUM_SOURCES-1:0]);
  assign tick_done = tick_reg == 32'(MINUTE_TICKS - 1);
  assign period_wr = wr_b0 && paddr == ADDR_TIMEOUT_PERIOD;

  // Minute prescaler; restarts whenever the count is reloaded.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= '0;
    end else if (!running_reg || period_wr || trigger || tick_done || dev_clear) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + 32'd1;
    end
  end

  // Counts down minutes and drives the timeout output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg     <= PERIOD_RESET;
      running_reg   <= 1'b0;
      timeout_out_n <= 1'b1;
    end else if (dev_clear) begin
      count_reg     <= PERIOD_RESET;
      running_reg   <= 1'b0;
      timeout_out_n <= 1'b1;
    end else if (period_wr) begin
      count_reg     <= pwdata[7:0];
      running_reg   <= pwdata[7:0] != PERIOD_RESET;
      timeout_out_n <= 1'b1;
    end else if (running_reg && trigger) begin
      count_reg <= timeout_period_reg;
    end else if (running_reg && tick_done) begin
      if (count_reg == 8'h01) begin
        count_reg     <= PERIOD_RESET;
        running_reg   <= 1'b0;
        timeout_out_n <= 1'b0;
      end else begin
        count_reg <= count_reg - 8'h01;
      end
    end
  end

  // ==========================================================================
  // Power-event request, lock status pulse and event mask.
  logic req;
  assign req = (acpi_support_reg[SUP_SLEEP_EN] && acpi_support_reg[SUP_SLEEP_STS])
            || (acpi_support_reg[SUP_LOCK_EN]  && acpi_support_reg[SUP_LOCK_STS])
            || (acpi_support_reg[SUP_SMI_EN]   && acpi_support_reg[SUP_SMI_STS]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_event_req_n <= 1'b1;
      lock_status_set   <= 1'b0;
      event_mask_only   <= 1'b0;
    end else begin
      power_event_req_n <= !req;
      lock_status_set   <= sup_wr && wbyte[SUP_BIOS_REL];
      event_mask_only   <= acpi_support_reg[SUP_MASK_EVT];
    end
  end

  // ==========================================================================
  // APB read data and response, one wait state per access.
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = ZERO_BYTE;
    unique case (paddr)
      ADDR_TIMEOUT_PERIOD: rd_byte = timeout_period_reg;
      ADDR_RELOAD_CFG:     rd_byte = reload_trigger_config_reg;
      ADDR_TIMEOUT_STATUS: rd_byte = {7'b0000000, timeout_out_n};
      ADDR_EVT_BASE_LO:    rd_byte = base_reg[0];
      ADDR_EVT_BASE_HI:    rd_byte = base_reg[1];
      ADDR_TMR_BASE_LO:    rd_byte = base_reg[2];
      ADDR_TMR_BASE_HI:    rd_byte = base_reg[3];
      ADDR_CTL_BASE_LO:    rd_byte = base_reg[4];
      ADDR_CTL_BASE_HI:    rd_byte = base_reg[5];
      ADDR_GP_BASE_LO:     rd_byte = base_reg[6];
      ADDR_GP_BASE_HI:     rd_byte = base_reg[7];
      ADDR_ACPI_SUPPORT:   rd_byte = acpi_support_reg & ~(8'h01 << SUP_BIOS_REL);
      default:             rd_byte = ZERO_BYTE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      prdata  <= (rd_en && !pready) ? {24'h000000, rd_byte} : '0;
    end
  end

  // ==========================================================================
  // Assertions.
  sequence s_zero_write;
    period_wr && pwdata[7:0] == PERIOD_RESET;
  endsequence

  a_zero_period_release: assert property (@(posedge pclk) disable iff (!presetn)
    s_zero_write |=> timeout_out_n && !running_reg)
    else $error("zero period did not stop timer");

  a_nonzero_release: assert property (@(posedge pclk) disable iff (!presetn)
    period_wr && !dev_clear |=> timeout_out_n)
    else $error("period write did not release output");

  a_expiry_low: assert property (@(posedge pclk) disable iff (!presetn)
    running_reg && tick_done && count_reg == 8'h01 && !trigger && !period_wr && !dev_clear
    |=> !timeout_out_n)
    else $error("expiry did not drive output low");

  a_reload_count: assert property (@(posedge pclk) disable iff (!presetn)
    running_reg && trigger && !period_wr && !dev_clear |=> count_reg == $past(timeout_period_reg))
    else $error("trigger did not reload count");

  a_clear_on_activate: assert property (@(posedge pclk) disable iff (!presetn)
    dev_clear |=> reload_trigger_config_reg == CFG_RESET && timeout_period_reg == PERIOD_RESET)
    else $error("activation did not clear enables");

  a_req_follows: assert property (@(posedge pclk) disable iff (!presetn)
    req |=> !power_event_req_n)
    else $error("request pin not asserted");

  a_sleep_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_enable_write |=> acpi_support_reg[SUP_SLEEP_STS])
    else $error("sleep flag not set");

  a_lock_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !acpi_support_reg[SUP_LOCK_EN]
    && !(acpi_support_reg[SUP_SLEEP_EN] && acpi_support_reg[SUP_SLEEP_STS])
    && !(acpi_support_reg[SUP_SMI_EN] && acpi_support_reg[SUP_SMI_STS]) |=> power_event_req_n)
    else $error("request without enable");

  // One minute tick that must take exactly one step off the count.
  sequence s_minute_step;
    running_reg && tick_done && count_reg != 8'h01 && !trigger && !period_wr && !dev_clear;
  endsequence

  a_minute_step: assert property (@(posedge pclk) disable iff (!presetn)
    s_minute_step |=> count_reg == $past(count_reg) - 8'h01)
    else $error("count did not step once per minute");

  a_period_kept: assert property (@(posedge pclk) disable iff (!presetn)
    !period_wr && !dev_clear |=> timeout_period_reg == $past(timeout_period_reg))
    else $error("period register changed without a write");

  a_sleep_held: assert property (@(posedge pclk) disable iff (!presetn)
    acpi_support_reg[SUP_SLEEP_STS] && !(sup_wr && wbyte[SUP_SLEEP_STS])
    |=> acpi_support_reg[SUP_SLEEP_STS])
    else $error("sleep flag cleared without a write of one");

  a_lock_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    lock_release_write |=> acpi_support_reg[SUP_LOCK_STS])
    else $error("lock flag not set");

  a_smi_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    smi_command_write |=> acpi_support_reg[SUP_SMI_STS])
    else $error("command flag not set");

  a_release_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    lock_status_set == $past(sup_wr && wbyte[SUP_BIOS_REL]))
    else $error("lock status pulse does not follow a write of one");

endmodule

// ### testbench/test_pmt_timeout_acpi.sv
// Self-checking bench for the supervision timer and ACPI support block.
`timescale 1ns/1ps
module test_pmt_timeout_acpi;
  import pmt_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, soft_reset, activate;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb, irq_sources;
  logic [2:0]  evt;
  logic        pready, pslverr, timeout_out_n, power_event_req_n, lock_status_set;
  logic        event_mask_only, e;
  int          n_errors, comparisons, cyc, pulses, p0;
  logic [7:0]  rst_v [12] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                              8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  ff_v  [12] = '{8'hFF, 8'h0F, 8'h01, 8'hFC, 8'hFF, 8'hFC, 8'hFF, 8'hFE,
                              8'hFF, 8'hF0, 8'hFF, 8'hCA};
  int          sts [3] = '{0, 2, 5};

  pmt_timeout_acpi #(.MINUTE_TICKS(10)) pmt_timeout_acpi_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .soft_reset(soft_reset), .activate(activate),
    .irq_sources(irq_sources), .sleep_enable_write(evt[0]),
    .lock_release_write(evt[1]), .smi_command_write(evt[2]),
    .timeout_out_n(timeout_out_n), .power_event_req_n(power_event_req_n),
    .lock_status_set(lock_status_set), .event_mask_only(event_mask_only));

  // ==========================================================================
  // Clock, pulse counter and hang guard.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (lock_status_set === 1'b1) pulses++;
    if (cyc == 8000) begin
      n_errors++;
      summarize();
    end
  end

  // ==========================================================================
  // Tasks.
  // Prints the verdict and ends the run.
  task automatic summarize();
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  // One APB transfer: setup, access held until pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h00000000);
    chk("prdata", {24'h000000, x}, q);
    chk("pslverr", 32'h0, e);
  endtask
  // Waits a bounded time for the timeout output to go low.
  task automatic expire(input int lim);
    int n;
    n = 0;
    while (timeout_out_n !== 1'b0 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk("timeout_out_n", 32'h0, timeout_out_n);
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    {psel, penable, pwrite, soft_reset, activate} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    irq_sources = 4'h0;
    evt = 3'h0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk("timeout_out_n", 32'h1, timeout_out_n);
    chk("power_event_req_n", 32'h1, power_event_req_n);
    for (int i = 0; i < 12; i++) rd(8'(4 * i), rst_v[i]);
    p0 = pulses;
    for (int i = 0; i < 12; i++) wr(8'(4 * i), 8'hFF);
    for (int i = 0; i < 12; i++) rd(8'(4 * i), ff_v[i]);
    chk("lock_status_set", p0 + 1, pulses);
    chk("event_mask_only", 32'h1, event_mask_only);
    wr(ADDR_ACPI_SUPPORT, 8'h00);
    wr(ADDR_TIMEOUT_PERIOD, 8'h00);
    apb(1'b0, 8'h30, 32'h00000000);
    chk("pslverr", 32'h1, e);
    chk("prdata", 32'h0, q);
    pstrb <= 4'hE;
    wr(ADDR_TIMEOUT_PERIOD, 8'h05);
    pstrb <= 4'hF;
    rd(ADDR_TIMEOUT_PERIOD, 8'h00);
    wr(ADDR_TIMEOUT_PERIOD, 8'h02);
    repeat (20) @(posedge pclk);
    chk("timeout_out_n", 32'h1, timeout_out_n);
    expire(1);
    rd(ADDR_TIMEOUT_PERIOD, 8'h02);
    rd(ADDR_TIMEOUT_STATUS, 8'h00);
    wr(ADDR_TIMEOUT_PERIOD, 8'h03);
    rd(ADDR_TIMEOUT_STATUS, 8'h01);
    wr(ADDR_TIMEOUT_PERIOD, 8'h00);
    repeat (45) @(posedge pclk);
    chk("timeout_out_n", 32'h1, timeout_out_n);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_RELOAD_CFG, 8'(1 << i));
      wr(ADDR_TIMEOUT_PERIOD, 8'h01);
      irq_sources <= 4'(1 << i);
      repeat (30) @(posedge pclk);
      chk("timeout_out_n", 32'h1, timeout_out_n);
      irq_sources <= 4'hF ^ 4'(1 << i);
      expire(25);
      irq_sources <= 4'h0;
    end
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_RELOAD_CFG, 8'h0F);
      wr(ADDR_TIMEOUT_PERIOD, 8'h01);
      expire(25);
      soft_reset <= (k == 0);
      activate <= (k == 1);
      @(posedge pclk);
      {soft_reset, activate} <= 2'b00;
      rd(ADDR_TIMEOUT_PERIOD, 8'h00);
      rd(ADDR_RELOAD_CFG, 8'h00);
      rd(ADDR_TIMEOUT_STATUS, 8'h01);
    end
    wr(ADDR_RELOAD_CFG, 8'h0F);
    wr(ADDR_TIMEOUT_PERIOD, 8'h01);
    expire(25);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    chk("timeout_out_n", 32'h1, timeout_out_n);
    rd(ADDR_TIMEOUT_PERIOD, 8'h00);
    rd(ADDR_RELOAD_CFG, 8'h00);
    rd(ADDR_TIMEOUT_STATUS, 8'h01);
    wr(ADDR_ACPI_SUPPORT, 8'h4A);
    for (int j = 0; j < 3; j++) begin
      evt <= 3'(1 << j);
      @(posedge pclk);
      evt <= 3'h0;
      rd(ADDR_ACPI_SUPPORT, 8'h4A | 8'(1 << sts[j]));
      chk("power_event_req_n", 32'h0, power_event_req_n);
      wr(ADDR_ACPI_SUPPORT, 8'h4A | 8'(1 << sts[j]));
      rd(ADDR_ACPI_SUPPORT, 8'h4A);
      chk("power_event_req_n", 32'h1, power_event_req_n);
    end
    wr(ADDR_ACPI_SUPPORT, 8'h00);
    evt <= 3'h7;
    @(posedge pclk);
    evt <= 3'h0;
    rd(ADDR_ACPI_SUPPORT, 8'h25);
    chk("power_event_req_n", 32'h1, power_event_req_n);
    wr(ADDR_ACPI_SUPPORT, 8'h25);
    rd(ADDR_ACPI_SUPPORT, 8'h00);
    chk("lock_status_set", p0 + 1, pulses);
    chk("event_mask_only", 32'h0, event_mask_only);
    summarize();
  end
endmodule
